//--- include/acp_cfg.svh
// Purpose: constants of the alarm and output port command interpreter
// Assumes: ASCII frames, one character per byte, carriage return ends a frame
// Notes:   offsets are character positions inside a frame, index 0 is the '@'
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

`define ACP_CH_START   8'h40
`define ACP_CH_CR      8'h0d
`define ACP_CH_OK      8'h21
`define ACP_CH_BAD     8'h3f
`define ACP_CH_PLUS    8'h2b
`define ACP_CH_MINUS   8'h2d
`define ACP_CH_DOT     8'h2e
`define ACP_CH_C       8'h43
`define ACP_CH_D       8'h44
`define ACP_CH_H       8'h48
`define ACP_CH_I       8'h49
`define ACP_CH_L       8'h4c
`define ACP_CH_M       8'h4d
`define ACP_CH_O       8'h4f

`define ACP_FRAME_MAX  17
`define ACP_LEN_SHORT  5'h05
`define ACP_LEN_CHAN   5'h07
`define ACP_LEN_LIMIT  5'h11
`define ACP_RESP_MAX   6

`define ACP_RST_PORT   8'h00

`endif

//--- include/acp_pkg.sv
// Purpose: types of the alarm and output port command interpreter
// Assumes: nothing beyond the cfg header
// Notes:   module-sized state lives in the module itself
package acp_pkg;
	typedef enum logic [1:0] {ACP_RX, ACP_EXEC, ACP_TX} acp_state_t;
endpackage

//--- verilog/acp_alarm_port.sv
// Purpose: alarm and output port command interpreter
// Assumes: rx bytes, readings, watchdog flag and module_id all on clk_sys
// Notes:   readings and limits are signed hundredths of a degree
`timescale 1ns/1ps
`include "acp_cfg.svh"

module acp_alarm_port #(
	parameter int NCH   = 8,
	parameter int NPORT = 8,
	parameter int RW    = 18
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire logic [7:0]        module_id,
	input  wire logic [7:0]        rx_data,
	input  wire logic              rx_valid,
	input  wire logic              rx_err,
	input  wire logic              wdt_timeout,
	input  wire logic [NCH*RW-1:0] reading_flat,
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	input  wire logic              tx_ready,
	output logic [NPORT-1:0]       port_out,
	output logic [NCH-1:0]         hi_alarm,
	output logic [NCH-1:0]         lo_alarm
);

	// --------------------------------------------------------------
	// parameter check
	// --------------------------------------------------------------
	generate
		if (NCH < 1 || NCH > 8 || NPORT < 1 || NPORT > 8 || RW < 18) begin : g_bad
			$error("acp_alarm_port: NCH and NPORT must be 1..8, RW at least 18");
		end
	endgenerate

	typedef struct packed {
		acp_pkg::acp_state_t                 st;
		logic [`ACP_FRAME_MAX-1:0][7:0]      fb;
		logic [4:0]                          len;
		logic                                bad;
		logic [`ACP_RESP_MAX-1:0][7:0]       resp;
		logic [2:0]                          last;
		logic [2:0]                          idx;
		logic [7:0]                          tx_data;
		logic                                tx_valid;
		logic [NCH-1:0][RW-1:0]              hi_lim;
		logic [NCH-1:0][RW-1:0]              lo_lim;
		logic [NCH-1:0][2:0]                 hi_port;
		logic [NCH-1:0][2:0]                 lo_port;
		logic [NCH-1:0]                      hi_en;
		logic [NCH-1:0]                      lo_en;
		logic [NCH-1:0]                      hi_latch;
		logic [NCH-1:0]                      lo_latch;
		logic [NCH-1:0]                      hi_act;
		logic [NCH-1:0]                      lo_act;
		logic [NPORT-1:0]                    owned;
		logic [NPORT-1:0]                    manual;
		logic [NPORT-1:0]                    dout;
	} acp_st_t;

	acp_st_t          s_ff;
	acp_st_t          nxt_s;
	logic             respond;
	logic             ok;
	logic             id_match;
	logic             is_do;
	logic             is_di;
	logic [NCH-1:0]   clr_hi_m;
	logic [NCH-1:0]   clr_lo_m;
	logic [NCH-1:0]   dis_hi_m;
	logic [NCH-1:0]   dis_lo_m;
	logic [NCH-1:0]   set_hi_m;
	logic [NCH-1:0]   set_lo_m;
	logic [NPORT-1:0] set_port_m;
	logic             set_latch;
	logic [NCH-1:0]   hcond;
	logic [NCH-1:0]   lcond;
	logic [NPORT-1:0] alarm_or;

	// --------------------------------------------------------------
	// character helpers
	// --------------------------------------------------------------
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
		if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b1, 4'(c[3:0] + 4'h9)};
		return 5'h00;
	endfunction

	function automatic logic [4:0] dec_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
		return 5'h00;
	endfunction

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		if (n < 4'ha) return {4'h3, n};
		return 8'(8'h37 + {4'h0, n});
	endfunction

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		logic [4:0]    ha;
		logic [4:0]    hb;
		logic [4:0]    chd;
		logic [4:0]    pd;
		logic [`ACP_FRAME_MAX-1:0][4:0] dd;
		logic [`ACP_FRAME_MAX-1:0][4:0] hh;
		logic [7:0]    wval;
		logic          fmt_lim;
		logic [RW-1:0] mag;
		logic [RW-1:0] lim;
		logic [7:0]    dv8;
		nxt_s = s_ff;
		ha = hex_val(s_ff.fb[1]);
		hb = hex_val(s_ff.fb[2]);
		for (int k = 0; k < `ACP_FRAME_MAX; k++) begin
			dd[k] = dec_val(s_ff.fb[k]);
			hh[k] = hex_val(s_ff.fb[k]);
		end
		chd = dd[6];
		pd = dd[16];
		wval = {ha[3:0], hb[3:0]};
		respond = 1'b0;
		ok = 1'b0;
		is_do = 1'b0;
		is_di = 1'b0;
		clr_hi_m = '0;
		clr_lo_m = '0;
		dis_hi_m = '0;
		dis_lo_m = '0;
		set_hi_m = '0;
		set_lo_m = '0;
		set_port_m = '0;
		set_latch = (s_ff.fb[14] == `ACP_CH_L);
		hcond = '0;
		lcond = '0;
		alarm_or = '0;
		dv8 = 8'h00;
		id_match = ha[4] && hb[4] && wval == module_id;
		fmt_lim = s_ff.len == `ACP_LEN_LIMIT
			&& (s_ff.fb[5] == `ACP_CH_PLUS || s_ff.fb[5] == `ACP_CH_MINUS)
			&& dd[6][4] && dd[7][4] && dd[8][4]
			&& s_ff.fb[9] == `ACP_CH_DOT && dd[10][4] && dd[11][4]
			&& s_ff.fb[12] == `ACP_CH_C && dd[13][4]
			&& (s_ff.fb[14] == `ACP_CH_M || s_ff.fb[14] == `ACP_CH_L)
			&& s_ff.fb[15] == `ACP_CH_O && pd[4];
		mag = RW'(dd[6][3:0]) * RW'(10000) + RW'(dd[7][3:0]) * RW'(1000)
			+ RW'(dd[8][3:0]) * RW'(100) + RW'(dd[10][3:0]) * RW'(10)
			+ RW'(dd[11][3:0]);
		lim = (s_ff.fb[5] == `ACP_CH_MINUS) ? RW'(-mag) : mag;

		// ----------------------------------------------------------
		// frame reception and dispatch
		// ----------------------------------------------------------
		case (s_ff.st)
			acp_pkg::ACP_RX: begin
				if (rx_valid) begin
					if (rx_data == `ACP_CH_START) begin
						nxt_s.fb[0] = rx_data;
						nxt_s.len = 5'h01;
						nxt_s.bad = rx_err;
					end else if (rx_data == `ACP_CH_CR) begin
						if (s_ff.len != 5'h00) nxt_s.st = acp_pkg::ACP_EXEC;
						nxt_s.bad = s_ff.bad | rx_err;
					end else if (s_ff.len != 5'h00) begin
						if (s_ff.len == 5'(`ACP_FRAME_MAX)) nxt_s.bad = 1'b1;
						else begin
							nxt_s.fb[s_ff.len] = rx_data;
							nxt_s.len = 5'(s_ff.len + 5'h01);
						end
						if (rx_err) nxt_s.bad = 1'b1;
					end
				end
			end
			acp_pkg::ACP_EXEC: begin
				nxt_s.len = 5'h00;
				nxt_s.bad = 1'b0;
				nxt_s.st = acp_pkg::ACP_RX;
				if (!s_ff.bad && id_match) begin
					if (s_ff.len == `ACP_LEN_CHAN && s_ff.fb[5] == `ACP_CH_C && chd[4]
						&& (s_ff.fb[3] == `ACP_CH_C || s_ff.fb[3] == `ACP_CH_D)
						&& (s_ff.fb[4] == `ACP_CH_H || s_ff.fb[4] == `ACP_CH_L)) begin
						respond = 1'b1;
						ok = 32'(chd[3:0]) < NCH;
						if (ok) begin
							if (s_ff.fb[3] == `ACP_CH_C && s_ff.fb[4] == `ACP_CH_H) clr_hi_m[chd[2:0]] = 1'b1;
							if (s_ff.fb[3] == `ACP_CH_C && s_ff.fb[4] == `ACP_CH_L) clr_lo_m[chd[2:0]] = 1'b1;
							if (s_ff.fb[3] == `ACP_CH_D && s_ff.fb[4] == `ACP_CH_H) dis_hi_m[chd[2:0]] = 1'b1;
							if (s_ff.fb[3] == `ACP_CH_D && s_ff.fb[4] == `ACP_CH_L) dis_lo_m[chd[2:0]] = 1'b1;
						end
					end else if (s_ff.len == `ACP_LEN_SHORT && s_ff.fb[3] == `ACP_CH_D
						&& s_ff.fb[4] == `ACP_CH_I) begin
						respond = 1'b1;
						ok = 1'b1;
						is_di = 1'b1;
					end else if (s_ff.len == `ACP_LEN_CHAN && s_ff.fb[3] == `ACP_CH_D
						&& s_ff.fb[4] == `ACP_CH_O && hh[5][4] && hh[6][4]) begin
						respond = 1'b1;
						is_do = 1'b1;
						ok = !wdt_timeout;
						if (ok) nxt_s.manual = NPORT'({hh[5][3:0], hh[6][3:0]});
					end else if (fmt_lim && ((s_ff.fb[3] == `ACP_CH_H && s_ff.fb[4] == `ACP_CH_I)
						|| (s_ff.fb[3] == `ACP_CH_L && s_ff.fb[4] == `ACP_CH_O))) begin
						respond = 1'b1;
						ok = 32'(dd[13][3:0]) < NCH && 32'(pd[3:0]) < NPORT;
						if (ok) begin
							if (s_ff.fb[3] == `ACP_CH_H) set_hi_m[dd[13][2:0]] = 1'b1;
							else set_lo_m[dd[13][2:0]] = 1'b1;
							set_port_m[pd[2:0]] = 1'b1;
						end
					end
				end
				if (respond) begin
					dv8 = 8'(s_ff.dout);
					nxt_s.resp[0] = ok ? `ACP_CH_OK : `ACP_CH_BAD;
					nxt_s.resp[1] = hex_chr(module_id[7:4]);
					nxt_s.resp[2] = hex_chr(module_id[3:0]);
					nxt_s.resp[3] = (is_di && ok) ? hex_chr(dv8[7:4]) : `ACP_CH_CR;
					nxt_s.resp[4] = hex_chr(dv8[3:0]);
					nxt_s.resp[5] = `ACP_CH_CR;
					nxt_s.last = (is_di && ok) ? 3'h5 : 3'h3;
					nxt_s.idx = 3'h0;
					nxt_s.tx_data = ok ? `ACP_CH_OK : `ACP_CH_BAD;
					nxt_s.tx_valid = 1'b1;
					nxt_s.st = acp_pkg::ACP_TX;
				end
			end
			acp_pkg::ACP_TX: begin
				if (tx_ready) begin
					if (s_ff.idx == s_ff.last) begin
						nxt_s.tx_valid = 1'b0;
						nxt_s.st = acp_pkg::ACP_RX;
					end else begin
						nxt_s.idx = 3'(s_ff.idx + 3'h1);
						nxt_s.tx_data = s_ff.resp[3'(s_ff.idx + 3'h1)];
					end
				end
			end
			default: begin
				nxt_s.st = acp_pkg::ACP_RX;
				nxt_s.tx_valid = 1'b0;
			end
		endcase

		// ----------------------------------------------------------
		// alarm evaluation and port drive
		// ----------------------------------------------------------
		for (int i = 0; i < NCH; i++) begin
			// reading and limit share the current scale
			hcond[i] = s_ff.hi_en[i] && $signed(reading_flat[i*RW +: RW]) > $signed(s_ff.hi_lim[i]);
			lcond[i] = s_ff.lo_en[i] && $signed(reading_flat[i*RW +: RW]) < $signed(s_ff.lo_lim[i]);
			nxt_s.hi_act[i] = hcond[i] | (s_ff.hi_latch[i] & s_ff.hi_act[i] & ~clr_hi_m[i]);
			nxt_s.lo_act[i] = lcond[i] | (s_ff.lo_latch[i] & s_ff.lo_act[i] & ~clr_lo_m[i]);
			if (s_ff.hi_act[i]) alarm_or[s_ff.hi_port[i]] = 1'b1;
			if (s_ff.lo_act[i]) alarm_or[s_ff.lo_port[i]] = 1'b1;
			if (dis_hi_m[i]) begin
				nxt_s.hi_en[i] = 1'b0;
				nxt_s.hi_act[i] = 1'b0;
			end
			if (dis_lo_m[i]) begin
				nxt_s.lo_en[i] = 1'b0;
				nxt_s.lo_act[i] = 1'b0;
			end
			if (set_hi_m[i]) begin
				nxt_s.hi_lim[i] = lim;
				nxt_s.hi_en[i] = 1'b1;
				nxt_s.hi_latch[i] = set_latch;
				nxt_s.hi_port[i] = pd[2:0];
			end
			if (set_lo_m[i]) begin
				nxt_s.lo_lim[i] = lim;
				nxt_s.lo_en[i] = 1'b1;
				nxt_s.lo_latch[i] = set_latch;
				nxt_s.lo_port[i] = pd[2:0];
			end
		end
		nxt_s.owned = s_ff.owned | set_port_m;
		nxt_s.dout = (s_ff.owned & alarm_or) | (~s_ff.owned & s_ff.manual);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_ff <= '0;
			s_ff.st <= acp_pkg::ACP_RX;
			s_ff.manual <= NPORT'(`ACP_RST_PORT);
			s_ff.dout <= NPORT'(`ACP_RST_PORT);
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tx_data = s_ff.tx_data;
	assign tx_valid = s_ff.tx_valid;
	assign port_out = s_ff.dout;
	assign hi_alarm = s_ff.hi_act;
	assign lo_alarm = s_ff.lo_act;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_silent;
		s_ff.st == acp_pkg::ACP_EXEC && (s_ff.bad || !id_match) |=> !tx_valid && s_ff.st == acp_pkg::ACP_RX;
	endproperty
	a_silent: assert property (p_silent) else $error("answer to a foreign or broken frame");

	property p_ok_frame;
		respond && ok |=> tx_valid && tx_data == `ACP_CH_OK && s_ff.resp[1] == hex_chr(module_id[7:4])
			&& s_ff.resp[2] == hex_chr(module_id[3:0]);
	endproperty
	a_ok_frame: assert property (p_ok_frame) else $error("valid answer malformed");

	property p_bad_frame;
		respond && !ok |=> tx_valid && tx_data == `ACP_CH_BAD && s_ff.last == 3'h3;
	endproperty
	a_bad_frame: assert property (p_bad_frame) else $error("invalid answer malformed");

	property p_wdt;
		respond && is_do && wdt_timeout |=> tx_data == `ACP_CH_BAD && $stable(s_ff.manual);
	endproperty
	a_wdt: assert property (p_wdt) else $error("port write taken during watchdog timeout");

	property p_port_mux;
		1 |=> port_out == (($past(s_ff.owned) & $past(alarm_or)) | (~$past(s_ff.owned) & $past(s_ff.manual)));
	endproperty
	a_port_mux: assert property (p_port_mux) else $error("port drive wrong");

	property p_clear_hi;
		(|clr_hi_m) && !(|(clr_hi_m & hcond)) |=> !(|(s_ff.hi_act & $past(clr_hi_m)));
	endproperty
	a_clear_hi: assert property (p_clear_hi) else $error("high alarm not cleared");

	property p_clear_lo;
		(|clr_lo_m) && !(|(clr_lo_m & lcond)) |=> !(|(s_ff.lo_act & $past(clr_lo_m)));
	endproperty
	a_clear_lo: assert property (p_clear_lo) else $error("low alarm not cleared");

	property p_off_hi;
		(|dis_hi_m) |=> !(|((s_ff.hi_act | s_ff.hi_en) & $past(dis_hi_m)));
	endproperty
	a_off_hi: assert property (p_off_hi) else $error("high alarm still enabled");

	property p_off_lo;
		(|dis_lo_m) |=> !(|((s_ff.lo_act | s_ff.lo_en) & $past(dis_lo_m)));
	endproperty
	a_off_lo: assert property (p_off_lo) else $error("low alarm still enabled");

	property p_hold;
		(|(s_ff.hi_act & s_ff.hi_latch & ~clr_hi_m & ~dis_hi_m)) |=>
			(s_ff.hi_act & $past(s_ff.hi_act & s_ff.hi_latch & ~clr_hi_m & ~dis_hi_m))
			== $past(s_ff.hi_act & s_ff.hi_latch & ~clr_hi_m & ~dis_hi_m);
	endproperty
	a_hold: assert property (p_hold) else $error("latched alarm dropped");

	property p_moment;
		1 |=> (s_ff.lo_act & ~$past(s_ff.lo_latch) & ~$past(dis_lo_m))
			== ($past(lcond) & ~$past(s_ff.lo_latch) & ~$past(dis_lo_m));
	endproperty
	a_moment: assert property (p_moment) else $error("momentary alarm wrong");

	property p_set;
		(|set_hi_m) |=> (|(s_ff.hi_en & $past(set_hi_m))) && (|(s_ff.owned & $past(set_port_m)))
			&& ((|(s_ff.hi_latch & $past(set_hi_m))) == $past(set_latch));
	endproperty
	a_set: assert property (p_set) else $error("high alarm setting not stored");

	property p_set_lo;
		(|set_lo_m) |=> (|(s_ff.lo_en & $past(set_lo_m))) && (|(s_ff.owned & $past(set_port_m)));
	endproperty
	a_set_lo: assert property (p_set_lo) else $error("low alarm setting not stored");

	property p_query;
		respond && is_di |=> s_ff.last == 3'h5 && s_ff.resp[4] == hex_chr(4'($past(s_ff.dout)));
	endproperty
	a_query: assert property (p_query) else $error("port query data wrong");

	c_query: cover property (respond && is_di ##[1:20] !tx_valid);
	c_latch_clear: cover property ((|(s_ff.hi_act & s_ff.hi_latch)) ##[1:200] (|clr_hi_m));
	c_write: cover property (respond && is_do && ok);

endmodule

//--- dv/acp_host_model.sv
// Purpose: host side of the command link: sends frames, gathers the answer
// Assumes: one character per clk_sys cycle, driven on the falling edge
// Notes:   slow=1 stalls the answer by toggling tx_ready
`timescale 1ns/1ps

module acp_host_model (
	input  wire logic       clk_sys,
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	output logic            rx_err,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready
);
	logic [7:0] rsp[$];
	logic       slow;

	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_err = 1'b0;
		tx_ready = 1'b1;
		slow = 1'b0;
	end

	// ----------------------------------------
	// answer collection
	// ----------------------------------------
	always @(negedge clk_sys) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	always @(posedge clk_sys) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			rsp.push_back(tx_data);
		end
	end

	// ----------------------------------------
	// frame sender: text then carriage return
	// ----------------------------------------
	task automatic send(input string f, input int err_at);
		for (int i = 0; i <= f.len(); i++) begin
			@(negedge clk_sys);
			rx_data = (i == f.len()) ? 8'h0d : f[i];
			rx_valid = 1'b1;
			rx_err = (i == err_at);
		end
		@(negedge clk_sys);
		rx_valid = 1'b0;
		rx_err = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule

//--- dv/acp_alarm_port_tb.sv
// Purpose: self-checking bench of the alarm and output port interpreter
// Assumes: module id 3a, eight channels, eight ports
// Notes:   every frame is followed by a 40 cycle answer window
`timescale 1ns/1ps

module acp_alarm_port_tb;
	localparam int RW = 18;
	logic              clk_sys;
	logic              rst_n;
	logic [7:0]        module_id;
	logic              wdt_timeout;
	logic [8*RW-1:0]   reading_flat;
	logic signed [RW-1:0] rd [8];
	logic [7:0]        rx_data;
	logic              rx_valid;
	logic              rx_err;
	logic [7:0]        tx_data;
	logic              tx_valid;
	logic              tx_ready;
	logic [7:0]        port_out;
	logic [7:0]        hi_alarm;
	logic [7:0]        lo_alarm;
	int                n_fail;
	int                checks_done;

	initial clk_sys = 1'b0;
	always #2.5 clk_sys = ~clk_sys;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			reading_flat[i*RW +: RW] = rd[i];
		end
	end

	acp_alarm_port #(.NCH(8), .NPORT(8), .RW(RW)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .module_id(module_id), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_err(rx_err), .wdt_timeout(wdt_timeout),
		.reading_flat(reading_flat), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .port_out(port_out), .hi_alarm(hi_alarm), .lo_alarm(lo_alarm)
	);

	acp_host_model host (
		.clk_sys(clk_sys), .rx_data(rx_data), .rx_valid(rx_valid), .rx_err(rx_err),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic give_verdict();
		if (n_fail == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [47:0] pk(input string s);
		logic [47:0] v;
		v = '0;
		for (int i = 0; i < s.len(); i++) begin
			v = {v[39:0], s[i]};
		end
		if (s.len() > 0) begin
			v = {v[39:0], 8'h0d};
		end
		return v;
	endfunction

	task automatic xact(input string f, input string exp, input int err_at = -1);
		logic [47:0] seen;
		host.rsp.delete();
		host.send(f, err_at);
		repeat (40) @(negedge clk_sys);
		seen = '0;
		foreach (host.rsp[i]) seen = {seen[39:0], host.rsp[i]};
		check(seen, pk(exp));
	endtask

	task automatic set_rd(input int ch, input int val);
		@(negedge clk_sys);
		rd[ch] = RW'(val);
		repeat (4) @(negedge clk_sys);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		n_fail = 0;
		checks_done = 0;
		rst_n = 1'b0;
		module_id = 8'h3a;
		wdt_timeout = 1'b0;
		foreach (rd[i]) rd[i] = '0;
		repeat (10) @(negedge clk_sys);
		rst_n = 1'b1;
		check(port_out, 8'h00);
		check({tx_valid, hi_alarm, lo_alarm}, 17'h0);
		xact("@01DI", "");
		xact("@3aDI", "", 3);
		xact("@3aDX", "");
		xact("@3aHI+090.00C0XO1", "");
		xact("@3aDI", "!3A00");
		xact("@3ADOa5", "!3A");
		check(port_out, 8'ha5);
		xact("@3aDI", "!3AA5");
		wdt_timeout = 1'b1;
		xact("@3aDO0f", "?3A");
		check(port_out, 8'ha5);
		wdt_timeout = 1'b0;
		xact("@3aHI+090.00C0MO1", "!3A");
		set_rd(0, 9001);
		check(hi_alarm, 8'h01);
		check(port_out, 8'ha7);
		set_rd(0, 9000);
		check(hi_alarm, 8'h00);
		xact("@3aDOff", "!3A");
		check(port_out, 8'hfd);
		xact("@3aLO-005.00C3LO1", "!3A");
		set_rd(3, -501);
		check(lo_alarm, 8'h08);
		check(port_out, 8'hff);
		set_rd(3, 0);
		check(lo_alarm, 8'h08);
		xact("@3aCLC3", "!3A");
		check(lo_alarm, 8'h00);
		check(port_out, 8'hfd);
		xact("@3aHI+000.00C2LO2", "!3A");
		set_rd(2, 1);
		set_rd(2, 0);
		check(hi_alarm, 8'h04);
		xact("@3aCHC2", "!3A");
		check(hi_alarm, 8'h00);
		xact("@3aDHC0", "!3A");
		set_rd(0, 9001);
		check(hi_alarm, 8'h00);
		xact("@3aDLC3", "!3A");
		set_rd(3, -501);
		check(lo_alarm, 8'h00);
		host.slow = 1'b1;
		xact("@3aDI", "!3AF9");
		host.slow = 1'b0;
		xact("@3aCHC9", "?3A");
		xact("@3aHI+010.00C1MO9", "?3A");
		give_verdict();
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		give_verdict();
	end
endmodule
